// ---- design/moag_top.sv ----
// moag_top: operand effective-address generation and vector fetch
// assumes opcode bytes, mode and registers come from the core on clock_i
// Overview of operation
// - stretch request high: system clock runs normal periods
// - stretch request low: system clock held by whole half periods
// - one single-phase system clock for processor and system
// - vectors fetched high byte then low byte from fixed locations
// - accumulator mode selects A or B, one byte long
// - immediate operand in byte two; stack and index loads use bytes two-three
// - direct mode address is byte two, page zero, two bytes
// - extended mode address is byte two high, byte three low
// - indexed adds byte two to index low, carry into high
// - indexed result kept in temporary register, index unchanged
// - implied mode address is the stack pointer or index register, one byte long
// - relative adds offset to pc plus two with carry or borrow
// - irq and nmi sampled while clock high; all requests serviced after instruction ends
// - maskable request needs mask clear; mask set when serviced
`timescale 1ns/1ps
module moag_top (
   input  wire logic                 clock_i,
   input  wire logic                 rst_i,
   input  wire logic                 clock_stretch_request_i,
   input  wire logic                 irq_n_i,
   input  wire logic                 nmi_n_i,
   input  wire logic                 swi_i,
   input  wire logic                 instr_done_i,
   input  wire logic                 mask_clear_i,
   input  wire logic                 start_i,
   input  wire moag_pkg::moag_mode_t mode_i,
   input  wire logic                 acc_b_i,
   input  wire logic                 load_stack_pointer_op_i,
   input  wire logic                 load_index_op_i,
   input  wire logic                 implied_sp_i,
   input  wire logic [7:0]           byte2_i,
   input  wire logic [7:0]           byte3_i,
   input  wire logic [15:0]          pc_i,
   input  wire logic [15:0]          index_i,
   input  wire logic [15:0]          stack_i,
   output logic                      sys_clk_o,
   output logic [15:0]               addr_o,
   output logic                      addr_valid_o,
   output logic                      selected_accumulator_o,
   output logic                      operand_in_instr_o,
   output logic [1:0]                instr_len_o,
   output logic [15:0]               temp_addr_o,
   output logic                      mask_o,
   output logic                      vec_fetch_o,
   output logic                      vec_high_o
);
   logic                stretch_s1, stretch_s2, irq_s1, irq_s2, nmi_s1, nmi_s2;
   logic                half_end, nmi_prev, nmi_pend, irq_seen;
   logic [1:0]          vstep;
   moag_pkg::moag_vec_t vsel;
   logic [15:0]         vbase;
   logic [8:0]          idx_low, rel_low;
   logic [7:0]          rel_high;
   logic [15:0]         next_addr;
   logic [1:0]          next_len;

   // stretch, irq and nmi pins pass two flops before any logic reads them
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         stretch_s1 <= 1'b1;
         stretch_s2 <= 1'b1;
         irq_s1     <= 1'b1;
         irq_s2     <= 1'b1;
         nmi_s1     <= 1'b1;
         nmi_s2     <= 1'b1;
      end else begin
         stretch_s1 <= clock_stretch_request_i;
         stretch_s2 <= stretch_s1;
         irq_s1     <= irq_n_i;
         irq_s2     <= irq_s1;
         nmi_s1     <= nmi_n_i;
         nmi_s2     <= nmi_s1;
      end
   end

   moag_clock_gen #(
      .HALF_CYCLES (moag_pkg::HALF_PERIOD)
   ) u_clk (
      .clock_i      (clock_i),
      .rst_i        (rst_i),
      .stretch_ok_i (stretch_s2),
      .sys_clk_o    (sys_clk_o),
      .half_end_o   (half_end)
   );

   // sign-extended offset: the bias of two is folded in as a 16-bit add
   assign idx_low  = {1'b0, index_i[7:0]} + {1'b0, byte2_i};
   assign rel_low  = {1'b0, pc_i[7:0]} + {1'b0, byte2_i};
   assign rel_high = pc_i[15:8] + {7'h00, rel_low[8]} - {7'h00, byte2_i[7]};

   always_comb begin
      next_addr = pc_i;
      next_len  = 2'h1;
      unique case (mode_i)
         moag_pkg::MOAG_ACC: next_len = 2'h1;
         moag_pkg::MOAG_IMM: begin
            next_addr = pc_i + 16'h0001;
            next_len  = (load_stack_pointer_op_i || load_index_op_i) ? 2'h3 : 2'h2;
         end
         moag_pkg::MOAG_DIR: begin
            next_addr = {8'h00, byte2_i};
            next_len  = 2'h2;
         end
         moag_pkg::MOAG_EXT: begin
            next_addr = {byte2_i, byte3_i};
            next_len  = 2'h3;
         end
         moag_pkg::MOAG_IDX: begin
            next_addr = {index_i[15:8] + {7'h00, idx_low[8]}, idx_low[7:0]};
            next_len  = 2'h2;
         end
         moag_pkg::MOAG_IMP: begin
            next_addr = implied_sp_i ? stack_i : index_i;
            next_len  = 2'h1;
         end
         moag_pkg::MOAG_REL: begin
            next_addr = {rel_high, rel_low[7:0]} + moag_pkg::PC_REL_BIAS;
            next_len  = 2'h2;
         end
         default: next_addr = pc_i;
      endcase
   end

   // index register is only read; the sum lands in the temporary register
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         temp_addr_o            <= 16'h0000;
         instr_len_o            <= 2'h1;
         operand_in_instr_o     <= 1'b0;
         selected_accumulator_o <= 1'b0;
      end else if (start_i) begin
         temp_addr_o            <= next_addr;
         instr_len_o            <= next_len;
         operand_in_instr_o     <= (mode_i == moag_pkg::MOAG_IMM);
         selected_accumulator_o <= acc_b_i;
      end
   end

   // requests sampled during the high phase; nmi is edge, irq is level
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         nmi_prev <= 1'b1;
         nmi_pend <= 1'b0;
         irq_seen <= 1'b0;
      end else begin
         if (sys_clk_o) begin
            nmi_prev <= nmi_s2;
            irq_seen <= !irq_s2;
         end
         if (sys_clk_o && nmi_prev && !nmi_s2) begin
            nmi_pend <= 1'b1;
         end else if (vstep == 2'h0 && vec_fetch_o && vsel == moag_pkg::MOAG_V_NMI) begin
            nmi_pend <= 1'b0;
         end
      end
   end

   always_comb begin
      unique case (vsel)
         moag_pkg::MOAG_V_RESTART: vbase = moag_pkg::VEC_RESTART;
         moag_pkg::MOAG_V_NMI:     vbase = moag_pkg::VEC_NMI;
         moag_pkg::MOAG_V_SWI:     vbase = moag_pkg::VEC_SWI;
         moag_pkg::MOAG_V_IRQ:     vbase = moag_pkg::VEC_IRQ;
      endcase
   end

   // vstep 2: high byte, 1: low byte; the high byte holds one whole system clock period, the low byte's vec_fetch_o only one core cycle; stepped at the fall
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         vstep        <= 2'h2;
         vsel         <= moag_pkg::MOAG_V_RESTART;
         vec_fetch_o  <= 1'b1;
         vec_high_o   <= 1'b1;
         addr_o       <= moag_pkg::RESET_ADDR;
         addr_valid_o <= 1'b0;
         mask_o       <= 1'b1;
      end else begin
         if (mask_clear_i) begin
            mask_o <= 1'b0;
         end
         if (vstep != 2'h0) begin
            if (half_end && !sys_clk_o) begin
               vec_fetch_o  <= 1'b1;
               vec_high_o   <= (vstep == 2'h2);
               addr_o       <= (vstep == 2'h2) ? vbase : vbase + 16'h0001;
               addr_valid_o <= 1'b1;
               vstep        <= vstep - 2'h1;
            end
         end else if (instr_done_i && (nmi_pend || swi_i || (irq_seen && !mask_o))) begin
            vsel         <= nmi_pend ? moag_pkg::MOAG_V_NMI :
                            swi_i ? moag_pkg::MOAG_V_SWI : moag_pkg::MOAG_V_IRQ;
            vstep        <= 2'h2;
            mask_o       <= 1'b1;
            vec_fetch_o  <= 1'b0;
            addr_valid_o <= 1'b0;
         end else begin
            vec_fetch_o  <= 1'b0;
            addr_valid_o <= start_i;
            if (start_i) begin
               addr_o <= next_addr;
            end
         end
      end
   end

   AST_IDX_ADDR: assert property (@(posedge clock_i) disable iff (rst_i)
      (start_i && mode_i == moag_pkg::MOAG_IDX) |=>
      temp_addr_o == $past(index_i) + {8'h00, $past(byte2_i)})
      else $error("indexed address wrong");
   AST_REL_ADDR: assert property (@(posedge clock_i) disable iff (rst_i)
      (start_i && mode_i == moag_pkg::MOAG_REL) |=>
      temp_addr_o == $past(pc_i) + 16'h0002 + {{8{$past(byte2_i[7])}}, $past(byte2_i)})
      else $error("relative address wrong");
   AST_EXT_ADDR: assert property (@(posedge clock_i) disable iff (rst_i)
      (start_i && mode_i == moag_pkg::MOAG_EXT) |=>
      (temp_addr_o == {$past(byte2_i), $past(byte3_i)} && instr_len_o == 2'h3))
      else $error("extended address wrong");
   AST_DIR_PAGE: assert property (@(posedge clock_i) disable iff (rst_i)
      (start_i && mode_i == moag_pkg::MOAG_DIR) |=>
      (temp_addr_o[15:8] == 8'h00 && instr_len_o == 2'h2))
      else $error("direct address off page zero");
   AST_ONE_BYTE: assert property (@(posedge clock_i) disable iff (rst_i)
      (start_i && (mode_i == moag_pkg::MOAG_ACC || mode_i == moag_pkg::MOAG_IMP)) |=>
      instr_len_o == 2'h1)
      else $error("one-byte mode has wrong length");
   AST_IMM_LEN: assert property (@(posedge clock_i) disable iff (rst_i)
      (start_i && mode_i == moag_pkg::MOAG_IMM && load_index_op_i) |=>
      instr_len_o == 2'h3)
      else $error("wide immediate load not three bytes");
   AST_VEC_ORDER: assert property (@(posedge clock_i) disable iff (rst_i)
      (vec_fetch_o && vec_high_o && $changed(addr_o)) |->
      (addr_o[0] == 1'b0 && addr_o[15:3] == 13'h1FFF))
      else $error("vector high byte address wrong");
   AST_MASK_HONOUR: assert property (@(posedge clock_i) disable iff (rst_i)
      ($past(mask_o) && vstep == 2'h2 && $changed(vstep)) |-> vsel != moag_pkg::MOAG_V_IRQ)
      else $error("masked request serviced");
   AST_MASK_SET: assert property (@(posedge clock_i) disable iff (rst_i)
      ($changed(vsel) && vsel == moag_pkg::MOAG_V_IRQ) |-> mask_o)
      else $error("mask not set on service");

   COV_IRQ: cover property (@(posedge clock_i) vec_fetch_o && vsel == moag_pkg::MOAG_V_IRQ);
   COV_NMI: cover property (@(posedge clock_i) vec_fetch_o && vsel == moag_pkg::MOAG_V_NMI);
   COV_STRETCH: cover property (@(posedge clock_i) sys_clk_o && !stretch_s2);
   COV_REL: cover property (@(posedge clock_i) start_i && mode_i == moag_pkg::MOAG_REL);
endmodule

// ---- design/moag_pkg.sv ----
// moag_pkg: constants shared by the operand address generator files
// assumes a 16-bit address bus, 8-bit data, one 250 MHz core clock
package moag_pkg;
   localparam logic [15:0] VEC_RESTART  = 16'hFFFE;
   localparam logic [15:0] VEC_NMI      = 16'hFFFC;
   localparam logic [15:0] VEC_SWI      = 16'hFFFA;
   localparam logic [15:0] VEC_IRQ      = 16'hFFF8;
   localparam logic [15:0] RESET_ADDR   = 16'hFFFF;
   localparam logic [15:0] PC_REL_BIAS  = 16'h0002;
   localparam logic [7:0]  RESET_BYTE   = 8'h00;
   localparam logic [3:0]  HALF_PERIOD  = 4'h2;
   localparam logic [3:0]  RESET_COUNT  = 4'h0;
   typedef enum logic [2:0] {
      MOAG_ACC, MOAG_IMM, MOAG_DIR, MOAG_EXT, MOAG_IDX, MOAG_IMP, MOAG_REL
   } moag_mode_t;
   typedef enum logic [1:0] {
      MOAG_V_RESTART, MOAG_V_NMI, MOAG_V_SWI, MOAG_V_IRQ
   } moag_vec_t;
endpackage

// ---- design/moag_clock_gen.sv ----
// moag_clock_gen: single-phase system clock with stretch on request
// assumes the stretch request is already synchronised to clock_i
`timescale 1ns/1ps
module moag_clock_gen #(
   parameter logic [3:0] HALF_CYCLES = moag_pkg::HALF_PERIOD
) (
   input  wire logic clock_i,
   input  wire logic rst_i,
   input  wire logic stretch_ok_i,
   output logic      sys_clk_o,
   output logic      half_end_o
);
   logic [3:0] count;
   logic       at_end;

   // refused at elaboration: a zero count would wrap the end point to 15, giving 16-cycle half periods
   if (HALF_CYCLES == 4'h0) begin : g_half_check
      $error("HALF_CYCLES must be nonzero");
   end

   assign at_end = (count == HALF_CYCLES - 4'h1);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         count <= moag_pkg::RESET_COUNT;
      end else if (at_end) begin
         count <= moag_pkg::RESET_COUNT;
      end else begin
         count <= count + 4'h1;
      end
   end

   // only the high phase holds while not ready: stretches are whole half periods
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sys_clk_o  <= 1'b0;
         half_end_o <= 1'b0;
      end else begin
         half_end_o <= 1'b0;
         if (at_end && (!sys_clk_o || stretch_ok_i)) begin
            sys_clk_o  <= ~sys_clk_o;
            half_end_o <= 1'b1;
         end
      end
   end

   AST_STRETCH_HOLDS: assert property (@(posedge clock_i) disable iff (rst_i)
      (sys_clk_o && !stretch_ok_i && at_end) |=> sys_clk_o)
      else $error("system clock fell during a stretch");
   AST_NORMAL_TOGGLE: assert property (@(posedge clock_i) disable iff (rst_i)
      (at_end && stretch_ok_i) |=> (sys_clk_o != $past(sys_clk_o)))
      else $error("system clock missed a normal toggle");
endmodule

// ---- verification/moag_mem_model.sv ----
// moag_mem_model: memory decode on the far side of the address generator
// assumes one slow page of 4 KB; every other address answers at once
`timescale 1ns/1ps
module moag_mem_model #(
   parameter logic [3:0] SLOW_PAGE = 4'hC,
   parameter logic [3:0] WAIT_CYC  = 4'h8
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        sys_clk_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        addr_valid_i,
   output logic             clock_stretch_request_o
);
   logic       sys_clk_d;
   logic       slow_pend;
   logic [3:0] wait_cnt;
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sys_clk_d <= 1'h0;
         slow_pend <= 1'h0;
         wait_cnt  <= 4'h0;
      end else begin
         sys_clk_d <= sys_clk_i;
         // the valid strobe lasts one core cycle, so a slow decode is held until a fall
         if (addr_valid_i && addr_i[15:12] == SLOW_PAGE) begin
            slow_pend <= 1'h1;
         end else if (sys_clk_d && !sys_clk_i) begin
            slow_pend <= 1'h0;
         end
         // dropped at the falling edge so the request lands before the next high phase
         if (sys_clk_d && !sys_clk_i && slow_pend) begin
            wait_cnt <= WAIT_CYC;
         end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
         end
      end
   end
   // request line is driven high whenever wait_cnt is zero
   assign clock_stretch_request_o = (wait_cnt == 4'h0);
endmodule

// ---- verification/mpu_operand_address_generator_tb_top.sv ----
// mpu_operand_address_generator_tb_top: self-checking bench for moag_top
// assumes moag_pkg, moag_top and moag_mem_model are compiled before it
`timescale 1ns/1ps
module mpu_operand_address_generator_tb_top;
   logic                 clock_i = 1'h0;
   logic                 rst_i = 1'h1;
   logic                 clock_stretch_request_i;
   logic                 irq_n_i = 1'h1;
   logic                 nmi_n_i = 1'h1;
   logic                 swi_i = 1'h0;
   logic                 instr_done_i = 1'h0;
   logic                 mask_clear_i = 1'h0;
   logic                 start_i = 1'h0;
   moag_pkg::moag_mode_t mode_i = moag_pkg::MOAG_ACC;
   logic                 acc_b_i = 1'h0;
   logic                 load_stack_pointer_op = 1'h0;
   logic                 load_index_op = 1'h0;
   logic                 implied_sp_i = 1'h1;
   logic [7:0]           byte2_i = 8'h00;
   logic [7:0]           byte3_i = 8'h00;
   logic [15:0]          pc_i = 16'h1000;
   logic [15:0]          index_i = 16'h20F8;
   logic [15:0]          stack_i = 16'h01FF;
   logic                 sys_clk_o, addr_valid_o, sel_acc, opnd_in;
   logic                 mask_o, vec_fetch_o, vec_high_o;
   logic [15:0]          addr_o, temp_addr_o;
   logic [1:0]           instr_len_o;
   int                   n_fail = 0;
   int                   compares = 0;
   int                   cyc = 0;
   int                   hp = int'(moag_pkg::HALF_PERIOD);

   moag_top u_dut (
      .clock_i                 (clock_i),
      .rst_i                   (rst_i),
      .clock_stretch_request_i (clock_stretch_request_i),
      .irq_n_i                 (irq_n_i),
      .nmi_n_i                 (nmi_n_i),
      .swi_i                   (swi_i),
      .instr_done_i            (instr_done_i),
      .mask_clear_i            (mask_clear_i),
      .start_i                 (start_i),
      .mode_i                  (mode_i),
      .acc_b_i                 (acc_b_i),
      .load_stack_pointer_op_i (load_stack_pointer_op),
      .load_index_op_i         (load_index_op),
      .implied_sp_i            (implied_sp_i),
      .byte2_i                 (byte2_i),
      .byte3_i                 (byte3_i),
      .pc_i                    (pc_i),
      .index_i                 (index_i),
      .stack_i                 (stack_i),
      .sys_clk_o               (sys_clk_o),
      .addr_o                  (addr_o),
      .addr_valid_o            (addr_valid_o),
      .selected_accumulator_o  (sel_acc),
      .operand_in_instr_o      (opnd_in),
      .instr_len_o             (instr_len_o),
      .temp_addr_o             (temp_addr_o),
      .mask_o                  (mask_o),
      .vec_fetch_o             (vec_fetch_o),
      .vec_high_o              (vec_high_o)
   );
   moag_mem_model u_mem (
      .clock_i                 (clock_i),
      .rst_i                   (rst_i),
      .sys_clk_i               (sys_clk_o),
      .addr_i                  (addr_o),
      .addr_valid_i            (addr_valid_o),
      .clock_stretch_request_o (clock_stretch_request_i)
   );

   always #2 clock_i = ~clock_i;

   task automatic end_of_test();
      if (n_fail == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // the whole run needs about 320 cycles; the ceiling leaves a wide margin
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic pulse(ref logic s);
      @(negedge clock_i);
      s = 1'h1;
      @(negedge clock_i);
      s = 1'h0;
   endtask

   task automatic addr_case(input moag_pkg::moag_mode_t m, input logic [7:0] b2,
                            input logic [15:0] ea, input logic [1:0] el);
      @(negedge clock_i);
      mode_i = m;
      byte2_i = b2;
      byte3_i = ea[7:0];
      start_i = 1'h1;
      @(negedge clock_i);
      start_i = 1'h0;
      chk("instr_len_o", {14'h0, el}, {14'h0, instr_len_o});
      if (!(m inside {moag_pkg::MOAG_ACC, moag_pkg::MOAG_IMM})) begin
         chk("temp_addr_o", ea, temp_addr_o);
         chk("addr_o", ea, addr_o);
         chk("addr_valid_o", 16'h1, {15'h0, addr_valid_o});
      end
   endtask

   // an all-ones address never opens a vector pair, so reset values are skipped
   task automatic vec_chk(input logic [15:0] v);
      int n;
      n = 0;
      while (!(vec_fetch_o === 1'h1 && vec_high_o === 1'h1 && addr_o !== 16'hFFFF)
             && n < 200) begin
         @(negedge clock_i);
         n++;
      end
      chk("vector_high", v, addr_o);
      while (!(vec_fetch_o === 1'h1 && vec_high_o === 1'h0) && n < 400) begin
         @(negedge clock_i);
         n++;
      end
      chk("vector_low", v | 16'h0001, addr_o);
      while (vec_fetch_o !== 1'h0 && n < 600) begin
         @(negedge clock_i);
         n++;
      end
   endtask

   task automatic meas(output int mx, output int odd);
      int h;
      h = 0;
      mx = 0;
      odd = 0;
      while (sys_clk_o !== 1'h0) @(negedge clock_i);
      repeat (80) begin
         @(negedge clock_i);
         if (sys_clk_o === 1'h1) begin
            h++;
         end else if (h > 0) begin
            mx = (h > mx) ? h : mx;
            odd += (h % hp != 0);
            h = 0;
         end
      end
   endtask

   task automatic mode_case();
      addr_case(moag_pkg::MOAG_DIR, 8'hFF, 16'h00FF, 2'h2);
      addr_case(moag_pkg::MOAG_IDX, 8'h10, 16'h2108, 2'h2);
      addr_case(moag_pkg::MOAG_REL, 8'h7F, 16'h1081, 2'h2);
      addr_case(moag_pkg::MOAG_REL, 8'h80, 16'h0F82, 2'h2);
      addr_case(moag_pkg::MOAG_IMP, 8'h00, 16'h01FF, 2'h1);
      implied_sp_i = 1'h0;
      addr_case(moag_pkg::MOAG_IMP, 8'h00, 16'h20F8, 2'h1);
      for (int b = 0; b < 2; b++) begin
         acc_b_i = b[0];
         addr_case(moag_pkg::MOAG_ACC, 8'h00, 16'h0000, 2'h1);
         chk("selected_accumulator_o", 16'(b), {15'h0, sel_acc});
      end
      addr_case(moag_pkg::MOAG_IMM, 8'h55, 16'h0000, 2'h2);
      chk("operand_in_instr_o", 16'h1, {15'h0, opnd_in});
      load_index_op = 1'h1;
      addr_case(moag_pkg::MOAG_IMM, 8'h55, 16'h0000, 2'h3);
      load_index_op = 1'h0;
      load_stack_pointer_op = 1'h1;
      addr_case(moag_pkg::MOAG_IMM, 8'h55, 16'h0000, 2'h3);
      load_stack_pointer_op = 1'h0;
   endtask

   task automatic stretch_case();
      int mx, odd;
      addr_case(moag_pkg::MOAG_EXT, 8'hC0, 16'hC010, 2'h3);
      meas(mx, odd);
      chk("stretched_high", 16'h1, {15'h0, mx > hp});
      chk("odd_half_periods", 16'h0, 16'(odd));
      addr_case(moag_pkg::MOAG_EXT, 8'h12, 16'h1234, 2'h3);
      repeat (16) @(negedge clock_i);
      meas(mx, odd);
      chk("normal_high", 16'(hp), 16'(mx));
   endtask

   task automatic int_case();
      irq_n_i = 1'h0;
      repeat (8) @(negedge clock_i);
      pulse(instr_done_i);
      repeat (20) @(negedge clock_i);
      chk("masked_irq_addr", 16'h1234, addr_o);
      pulse(mask_clear_i);
      chk("mask_o", 16'h0, {15'h0, mask_o});
      pulse(instr_done_i);
      vec_chk(moag_pkg::VEC_IRQ);
      chk("mask_o", 16'h1, {15'h0, mask_o});
      irq_n_i = 1'h1;
      nmi_n_i = 1'h0;
      repeat (8) @(negedge clock_i);
      chk("nmi_waits_addr", 16'hFFF9, addr_o);
      pulse(instr_done_i);
      vec_chk(moag_pkg::VEC_NMI);
      nmi_n_i = 1'h1;
      swi_i = 1'h1;
      pulse(instr_done_i);
      swi_i = 1'h0;
      vec_chk(moag_pkg::VEC_SWI);
   endtask

   initial begin
      repeat (20) @(negedge clock_i);
      rst_i = 1'h0;
      vec_chk(moag_pkg::VEC_RESTART);
      chk("mask_o", 16'h1, {15'h0, mask_o});
      mode_case();
      stretch_case();
      int_case();
      end_of_test();
   end
endmodule
